// ---- hdl/mad_pkg.sv ----
// Constants, region codes and decode helpers for the core address decoder.
// Assumes a 16-bit core address bus and 8-bit special-function data.
package mad_pkg;

    // ==========================================================
    // Address windows
    localparam logic [15:0] MAD_LOW_HI    = 16'h03FF;
    localparam logic [15:0] MAD_SRAM_LO   = 16'h0400;
    localparam logic [15:0] MAD_SRAM_HI   = 16'h06FF;
    localparam logic [15:0] MAD_TSTA_LO   = 16'h30F0;
    localparam logic [15:0] MAD_TSTA_HI   = 16'h30F3;
    localparam logic [15:0] MAD_ATA_LO    = 16'h31F0;
    localparam logic [15:0] MAD_ATA_HI    = 16'h31F7;
    localparam logic [15:0] MAD_ATA_ALT   = 16'h33F6;
    localparam logic [15:0] MAD_TSTB_LO   = 16'h3F00;
    localparam logic [15:0] MAD_TSTB_HI   = 16'h3F2F;
    localparam int          MAD_SRAM_DEPTH = 768;
    localparam int          MAD_CFG_CODE_SRAM = 7;

    // ==========================================================
    // Special-function register offsets
    localparam logic [7:0] MAD_IRQ0_SOURCE   = 8'h80;
    localparam logic [7:0] MAD_IRQ1_SOURCE   = 8'h90;
    localparam logic [7:0] MAD_IRQ0_MASK     = 8'h93;
    localparam logic [7:0] MAD_IRQ1_MASK     = 8'h94;
    localparam logic [7:0] MAD_CHIP_REVISION = 8'h95;
    localparam logic [7:0] MAD_CHIP_IDENTITY = 8'h96;
    localparam logic [7:0] MAD_PIN_DIRECTION = 8'h97;
    localparam logic [7:0] MAD_PIN_OUT_VALUE = 8'h9A;
    localparam logic [7:0] MAD_PIN_IN_VALUE  = 8'h9B;
    localparam logic [7:0] MAD_PIN_IRQ_MASK  = 8'h9C;
    localparam logic [7:0] MAD_MISC_CONFIG   = 8'h9D;
    localparam logic [7:0] MAD_RAM_PORT_DATA = 8'h9F;
    localparam logic [7:0] MAD_WAKEUP_SOURCE = 8'hA0;
    localparam logic [7:0] MAD_RAM_ADDR_LOW  = 8'hA1;
    localparam logic [7:0] MAD_RAM_ADDR_HIGH = 8'hA2;
    localparam logic [7:0] MAD_CLOCK_SELECT  = 8'hA5;
    localparam logic [7:0] MAD_WAKEUP_MASK   = 8'hA6;
    localparam logic [7:0] MAD_PIN_IRQ_STAT  = 8'hC0;
    localparam logic [7:0] MAD_REG_RESET     = 8'h00;
    localparam logic [7:0] MAD_ZERO_BYTE     = 8'h00;

    // ==========================================================
    // External-data regions
    typedef enum logic [3:0] {
        MAD_RG_EXT  = 4'h1,
        MAD_RG_ATA  = 4'h2,
        MAD_RG_SRAM = 4'h4,
        MAD_RG_TEST = 4'h8
    } mad_region_t;

    function automatic logic mad_in(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    function automatic mad_region_t mad_xd_region(input logic [15:0] a);
        if (mad_in(a, MAD_SRAM_LO, MAD_SRAM_HI))
            return MAD_RG_SRAM;
        if (mad_in(a, MAD_TSTA_LO, MAD_TSTA_HI) || mad_in(a, MAD_TSTB_LO, MAD_TSTB_HI))
            return MAD_RG_TEST;
        if (mad_in(a, MAD_ATA_LO, MAD_ATA_HI) || (a == MAD_ATA_ALT))
            return MAD_RG_ATA;
        return MAD_RG_EXT;
    endfunction

    function automatic logic [9:0] mad_sram_index(input logic [15:0] a);
        logic [15:0] d;
        d = a - MAD_SRAM_LO;
        return d[9:0];
    endfunction

endpackage

// ---- hdl/mad_sram.sv ----
// Internal scratch memory with one write port and several read ports.
// Assumes the caller has already arbitrated between writers.
`timescale 1ns/1ps
`default_nettype none

module mad_sram #(
    parameter int DEPTH = 768,
    parameter int RD_PORTS = 3
) (
    // Clock
    input  wire logic                    sys_clk,
    // Write port
    input  wire logic                    wr_en,
    input  wire logic [9:0]              wr_idx,
    input  wire logic [7:0]              wr_data,
    // Read ports, combinational
    input  wire logic [RD_PORTS*10-1:0]  rd_idx,
    output logic      [RD_PORTS*8-1:0]   rd_data
);
    logic [7:0] mem [DEPTH];

    // ==========================================================
    // Storage
    // Left without reset on purpose so that it maps onto plain memory.
    always_ff @(posedge sys_clk) begin
        if (wr_en && (int'(wr_idx) < DEPTH)) begin
            mem[wr_idx] <= wr_data;
        end
    end

    // ==========================================================
    // Reads
    // Indexes past the end read as zero.
    always_comb begin
        for (int i = 0; i < RD_PORTS; i++) begin
            if (int'(rd_idx[i*10 +: 10]) < DEPTH)
                rd_data[i*8 +: 8] = mem[rd_idx[i*10 +: 10]];
            else
                rd_data[i*8 +: 8] = 8'h00;
        end
    end

endmodule

`default_nettype wire

// ---- hdl/mad_irq_gate.sv ----
// Folds each source register with its mask onto one core interrupt line.
// Assumes sources and masks are registers of the caller's clock domain.
`timescale 1ns/1ps
`default_nettype none

module mad_irq_gate #(
    parameter int LINES = 4
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    // Sources and masks, eight bits per line
    input  wire logic [LINES*8-1:0] src,
    input  wire logic [LINES*8-1:0] mask,
    // Interrupt lines
    output logic      [LINES-1:0]   irq
);
    // ==========================================================
    // Gate
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irq <= '0;
        end else begin
            for (int i = 0; i < LINES; i++) begin
                irq[i] <= |(src[i*8 +: 8] & mask[i*8 +: 8]);
            end
        end
    end

endmodule

`default_nettype wire

// ---- hdl/mad_decoder.sv ----
// Address decoder and runtime register block beside the embedded core.
// Assumes the core issues at most one code fetch and one data access per cycle.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Code space is one flat 64K byte range decoded from a 16-bit address.
// - Fetches below 0x0400 and from 0x0700 upward go to external program memory unless a data access takes the same cycle.
// - Fetches in 0x0400-0x06FF come from internal SRAM when config bit 7 is set.
// - Data accesses in 0x0400-0x06FF are served by the internal SRAM only.
// - Data accesses in the general external ranges raise the I/O read or write strobe.
// - The eight ATA registers and the ATA alternate address decode as ATA I/O cycles.
// - Data accesses below 0x0400 are external cycles with an I/O strobe.
// - Runtime registers are reached through the direct special-function path.
// - Runtime registers answer alongside the core's own special-function registers.
// - Pin interrupt status and its mask drive core interrupt three.
// - Wakeup source and its mask drive core interrupt two.
// - Source registers zero and one with their masks drive interrupts zero and one.
// - Revision and identity registers are read only.
module mad_decoder #(
    parameter logic [7:0] REVISION = 8'h01,  // Arbitrary value.
    parameter logic [7:0] IDENTITY = 8'h5A   // Arbitrary value.
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // Code fetch
    input  wire logic        code_req,
    input  wire logic [15:0] code_addr,
    output logic             code_valid,
    output logic             code_from_sram,
    output logic [7:0]       code_rdata,
    // External data access
    input  wire logic        xd_rd,
    input  wire logic        xd_wr,
    input  wire logic [15:0] xd_addr,
    input  wire logic [7:0]  xd_wdata,
    output logic             xd_valid,
    output logic [7:0]       xd_rdata,
    // Special-function access
    input  wire logic        sfr_rd,
    input  wire logic        sfr_wr,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic [7:0]  sfr_wdata,
    output logic             sfr_hit,
    output logic [7:0]       sfr_rdata,
    // External bus
    output logic [15:0]      ext_addr,
    output logic [7:0]       ext_wdata,
    output logic             memory_read_strobe,
    output logic             io_read_strobe,
    output logic             io_write_strobe,
    output logic             ata_select,
    // General purpose pins and events
    input  wire logic [7:0]  gpio_in,
    output logic [7:0]       gpio_out,
    output logic [7:0]       gpio_oe,
    input  wire logic [7:0]  irq0_event,
    input  wire logic [7:0]  irq1_event,
    input  wire logic [7:0]  wakeup_event,
    output logic [7:0]       core_clock_select,
    // Core interrupts
    output logic             core_irq_input_a,
    output logic             core_irq_input_b,
    output logic             wakeup_irq_input,
    output logic             pin_irq_input
);
    import mad_pkg::*;

    // ==========================================================
    // Decode
    mad_region_t xd_region;
    logic        xd_act;
    logic        code_sram;
    logic        xd_ext;
    logic [23:0] rd_data;
    logic [9:0]  port_idx;
    logic        sram_we;
    logic [9:0]  sram_widx;
    logic [7:0]  sram_wdata;

    logic [7:0] irq0_source_r, irq1_source_r, irq0_mask_r, irq1_mask_r;
    logic [7:0] pin_direction_r, pin_output_value_r, pin_irq_mask_r, pin_irq_status_r;
    logic [7:0] misc_configuration_r, wakeup_source_r, wakeup_mask_r;
    logic [7:0] ram_port_addr_low_r, ram_port_addr_high_r, core_clock_select_r;
    logic [7:0] pin_in_r, pin_in_prev_r;
    logic       pin_primed_r;

    assign xd_act    = xd_rd || xd_wr;
    assign xd_region = mad_xd_region(xd_addr);
    assign code_sram = mad_in(code_addr, MAD_SRAM_LO, MAD_SRAM_HI)
                       && misc_configuration_r[MAD_CFG_CODE_SRAM];
    assign xd_ext    = (xd_region == MAD_RG_EXT) || (xd_region == MAD_RG_ATA);
    assign port_idx  = {ram_port_addr_high_r[1:0], ram_port_addr_low_r};

    // A data write wins the single write port; a data-port write that
    // collides with it in the same cycle is dropped.
    assign sram_we    = (xd_wr && xd_region == MAD_RG_SRAM)
                        || (sfr_wr && sfr_addr == MAD_RAM_PORT_DATA);
    assign sram_widx  = (xd_wr && xd_region == MAD_RG_SRAM) ? mad_sram_index(xd_addr)
                                                            : port_idx;
    assign sram_wdata = (xd_wr && xd_region == MAD_RG_SRAM) ? xd_wdata : sfr_wdata;

    mad_sram #(
        .DEPTH    (MAD_SRAM_DEPTH),
        .RD_PORTS (3)
    ) u_sram (
        .sys_clk (sys_clk),
        .wr_en   (sram_we),
        .wr_idx  (sram_widx),
        .wr_data (sram_wdata),
        .rd_idx  ({port_idx, mad_sram_index(code_addr), mad_sram_index(xd_addr)}),
        .rd_data (rd_data)
    );

    // ==========================================================
    // External cycles
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            memory_read_strobe <= 1'b0;
            io_read_strobe     <= 1'b0;
            io_write_strobe    <= 1'b0;
            ata_select         <= 1'b0;
            ext_addr           <= 16'h0000;
            ext_wdata          <= 8'h00;
        end else begin
            memory_read_strobe <= code_req && !code_sram && !xd_act;
            io_read_strobe     <= xd_rd && xd_ext;
            io_write_strobe    <= xd_wr && !xd_rd && xd_ext;
            ata_select         <= xd_act && (xd_region == MAD_RG_ATA);
            if (xd_act) begin
                ext_addr <= xd_addr;
            end else if (code_req) begin
                ext_addr <= code_addr;
            end
            if (xd_wr && xd_ext) begin
                ext_wdata <= xd_wdata;
            end
        end
    end

    // ==========================================================
    // Internal answers
    // Reserved test windows read as zero and swallow writes.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            code_valid     <= 1'b0;
            code_from_sram <= 1'b0;
            code_rdata     <= 8'h00;
            xd_valid       <= 1'b0;
            xd_rdata       <= 8'h00;
        end else begin
            code_valid     <= code_req;
            code_from_sram <= code_req && code_sram;
            code_rdata     <= (code_req && code_sram) ? rd_data[15:8] : MAD_ZERO_BYTE;
            xd_valid       <= xd_act && !xd_ext;
            xd_rdata       <= (xd_rd && xd_region == MAD_RG_SRAM) ? rd_data[7:0]
                                                                  : MAD_ZERO_BYTE;
        end
    end

    // ==========================================================
    // Runtime register writes
    // Event bits are set by hardware and cleared by writing ones; an event
    // in the clearing cycle keeps its bit set.
    function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] evt,
                                       input logic hit);
        return (cur & ~(hit ? sfr_wdata : 8'h00)) | evt;
    endfunction

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irq0_source_r   <= MAD_REG_RESET;
            irq1_source_r   <= MAD_REG_RESET;
            wakeup_source_r <= MAD_REG_RESET;
            pin_irq_status_r <= MAD_REG_RESET;
        end else begin
            irq0_source_r   <= w1c(irq0_source_r, irq0_event,
                                   sfr_wr && sfr_addr == MAD_IRQ0_SOURCE);
            irq1_source_r   <= w1c(irq1_source_r, irq1_event,
                                   sfr_wr && sfr_addr == MAD_IRQ1_SOURCE);
            wakeup_source_r <= w1c(wakeup_source_r, wakeup_event,
                                   sfr_wr && sfr_addr == MAD_WAKEUP_SOURCE);
            pin_irq_status_r <= w1c(pin_irq_status_r,
                                    (pin_in_r ^ pin_in_prev_r) & ~pin_direction_r,
                                    sfr_wr && sfr_addr == MAD_PIN_IRQ_STAT);
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irq0_mask_r          <= MAD_REG_RESET;
            irq1_mask_r          <= MAD_REG_RESET;
            pin_direction_r      <= MAD_REG_RESET;
            pin_output_value_r   <= MAD_REG_RESET;
            pin_irq_mask_r       <= MAD_REG_RESET;
            misc_configuration_r <= MAD_REG_RESET;
            ram_port_addr_low_r  <= MAD_REG_RESET;
            ram_port_addr_high_r <= MAD_REG_RESET;
            core_clock_select_r  <= MAD_REG_RESET;
            wakeup_mask_r        <= MAD_REG_RESET;
        end else if (sfr_wr) begin
            // Revision and identity have no write path at all.
            unique case (sfr_addr)
                MAD_IRQ0_MASK:     irq0_mask_r          <= sfr_wdata;
                MAD_IRQ1_MASK:     irq1_mask_r          <= sfr_wdata;
                MAD_PIN_DIRECTION: pin_direction_r      <= sfr_wdata;
                MAD_PIN_OUT_VALUE: pin_output_value_r   <= sfr_wdata;
                MAD_PIN_IRQ_MASK:  pin_irq_mask_r       <= sfr_wdata;
                MAD_MISC_CONFIG:   misc_configuration_r <= sfr_wdata;
                MAD_RAM_ADDR_LOW:  ram_port_addr_low_r  <= sfr_wdata;
                MAD_RAM_ADDR_HIGH: ram_port_addr_high_r <= sfr_wdata;
                MAD_CLOCK_SELECT:  core_clock_select_r  <= sfr_wdata;
                MAD_WAKEUP_MASK:   wakeup_mask_r        <= sfr_wdata;
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Pins
    // Both stages load the pin on the first edge after reset, so no false edge.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pin_primed_r      <= 1'b0;
            pin_in_r          <= 8'h00;
            pin_in_prev_r     <= 8'h00;
            gpio_out          <= 8'h00;
            gpio_oe           <= 8'h00;
            core_clock_select <= 8'h00;
        end else begin
            pin_primed_r      <= 1'b1;
            pin_in_r          <= gpio_in;
            pin_in_prev_r     <= pin_primed_r ? pin_in_r : gpio_in;
            gpio_out          <= pin_output_value_r;
            gpio_oe           <= pin_direction_r;
            core_clock_select <= core_clock_select_r;
        end
    end

    // ==========================================================
    // Runtime register reads
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sfr_hit   <= 1'b0;
            sfr_rdata <= 8'h00;
        end else begin
            sfr_hit   <= 1'b0;
            sfr_rdata <= MAD_ZERO_BYTE;
            if (sfr_rd) begin
                sfr_hit <= 1'b1;
                unique case (sfr_addr)
                    MAD_IRQ0_SOURCE:   sfr_rdata <= irq0_source_r;
                    MAD_IRQ1_SOURCE:   sfr_rdata <= irq1_source_r;
                    MAD_IRQ0_MASK:     sfr_rdata <= irq0_mask_r;
                    MAD_IRQ1_MASK:     sfr_rdata <= irq1_mask_r;
                    MAD_CHIP_REVISION: sfr_rdata <= REVISION;
                    MAD_CHIP_IDENTITY: sfr_rdata <= IDENTITY;
                    MAD_PIN_DIRECTION: sfr_rdata <= pin_direction_r;
                    MAD_PIN_OUT_VALUE: sfr_rdata <= pin_output_value_r;
                    MAD_PIN_IN_VALUE:  sfr_rdata <= pin_in_r;
                    MAD_PIN_IRQ_MASK:  sfr_rdata <= pin_irq_mask_r;
                    MAD_MISC_CONFIG:   sfr_rdata <= misc_configuration_r;
                    MAD_RAM_PORT_DATA: sfr_rdata <= rd_data[23:16];
                    MAD_WAKEUP_SOURCE: sfr_rdata <= wakeup_source_r;
                    MAD_RAM_ADDR_LOW:  sfr_rdata <= ram_port_addr_low_r;
                    MAD_RAM_ADDR_HIGH: sfr_rdata <= ram_port_addr_high_r;
                    MAD_CLOCK_SELECT:  sfr_rdata <= core_clock_select_r;
                    MAD_WAKEUP_MASK:   sfr_rdata <= wakeup_mask_r;
                    MAD_PIN_IRQ_STAT:  sfr_rdata <= pin_irq_status_r;
                    default:           sfr_hit   <= 1'b0;
                endcase
            end
        end
    end

    // ==========================================================
    // Interrupt lines
    mad_irq_gate #(
        .LINES (4)
    ) u_irq (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .src     ({pin_irq_status_r, wakeup_source_r, irq1_source_r, irq0_source_r}),
        .mask    ({pin_irq_mask_r, wakeup_mask_r, irq1_mask_r, irq0_mask_r}),
        .irq     ({pin_irq_input, wakeup_irq_input, core_irq_input_b, core_irq_input_a})
    );

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_ext_read;
        xd_rd && xd_ext ##1 io_read_strobe && !io_write_strobe;
    endsequence
    sequence s_ext_write;
        xd_wr && !xd_rd && xd_ext ##1 io_write_strobe && !io_read_strobe;
    endsequence
    a_ext_read_strobe: assert property (xd_rd && xd_ext |-> s_ext_read
        ) else $error("external read missed its strobe");
    a_ext_write_strobe: assert property (xd_wr && !xd_rd && xd_ext |-> s_ext_write
        ) else $error("external write missed its strobe");
    a_ext_addr_follow: assert property (xd_act |=> ext_addr == $past(xd_addr)
        ) else $error("external address does not follow data access");
    a_ata_cycle_decode: assert property (xd_act && xd_region == MAD_RG_ATA
        |=> ata_select && (io_read_strobe || io_write_strobe)
        ) else $error("ATA access not decoded as ATA cycle");
    a_internal_no_strobe: assert property (xd_act && !xd_ext
        |=> !io_read_strobe && !io_write_strobe && xd_valid
        ) else $error("internal access raised an external strobe");
    a_low_fetch_ext: assert property (code_req && !xd_act
        && !mad_in(code_addr, MAD_SRAM_LO, MAD_SRAM_HI)
        |=> memory_read_strobe && !code_from_sram
        ) else $error("fixed code region not fetched externally");
    a_window_code_select: assert property (code_req && !xd_act
        && mad_in(code_addr, MAD_SRAM_LO, MAD_SRAM_HI)
        |=> code_from_sram == $past(misc_configuration_r[MAD_CFG_CODE_SRAM])
            && code_from_sram != memory_read_strobe
        ) else $error("code window source does not follow configuration");
    a_id_read_only: assert property (sfr_rd && (sfr_addr == MAD_CHIP_REVISION
        || sfr_addr == MAD_CHIP_IDENTITY)
        |=> sfr_hit && sfr_rdata == ($past(sfr_addr) == MAD_CHIP_REVISION ? REVISION : IDENTITY)
        ) else $error("read-only register changed");
    a_pin_irq_follow: assert property (|(pin_irq_status_r & pin_irq_mask_r)
        |=> pin_irq_input
        ) else $error("pin interrupt not raised");
    a_wake_irq_follow: assert property (!(|(wakeup_source_r & wakeup_mask_r))
        |=> !wakeup_irq_input
        ) else $error("wakeup interrupt raised without cause");
    a_src_irq_follow: assert property ((|(irq0_source_r & irq0_mask_r))
        ##1 1'b1 |-> core_irq_input_a
        ) else $error("interrupt zero not raised");

endmodule

`default_nettype wire

// ---- tb/mad_core_model.sv ----
// Core model: issues data-space and special-function accesses for the bench.
// Assumes the bench calls its tasks one at a time from a single process.
`timescale 1ns/1ps
`default_nettype none
module mad_core_model
    import mad_pkg::*;
(
    // Clock
    input  wire logic        sys_clk,
    // Data-space and register requests
    output logic             xd_rd,
    output logic             xd_wr,
    output logic [15:0]      xd_addr,
    output logic [7:0]       xd_wdata,
    output logic             sfr_rd,
    output logic             sfr_wr,
    output logic [7:0]       sfr_addr,
    output logic [7:0]       sfr_wdata
);
    // ==========================================================
    // Requests
    initial begin
        {xd_rd, xd_wr, xd_addr, xd_wdata, sfr_rd, sfr_wr, sfr_addr, sfr_wdata} = '0;
    end
    // The reserved test windows are skipped, as real firmware must.
    task automatic xd(input logic wr, input logic [15:0] a, input logic [7:0] d);
        if (!((a >= MAD_TSTA_LO && a <= MAD_TSTA_HI) || (a >= MAD_TSTB_LO && a <= MAD_TSTB_HI))) begin
            @(posedge sys_clk);
            xd_rd <= !wr;
            xd_wr <= wr;
            xd_addr <= a;
            xd_wdata <= d;
            @(posedge sys_clk);
            xd_rd <= 1'b0;
            xd_wr <= 1'b0;
            xd_addr <= ~a;
        end
    endtask
    task automatic special_function_region(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        sfr_rd <= !wr;
        sfr_wr <= wr;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge sys_clk);
        sfr_rd <= 1'b0;
        sfr_wr <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the core address decoder.
// Assumes the core model drives all data and register requests.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import mad_pkg::*;
    logic        sys_clk, resetn, code_req, code_valid, code_from_sram, xd_rd, xd_wr, xd_valid;
    logic        sfr_rd, sfr_wr, sfr_hit, memory_read_strobe, io_read_strobe, io_write_strobe;
    logic        ata_select, core_irq_input_a, core_irq_input_b, wakeup_irq_input, pin_irq_input;
    logic [15:0] code_addr, xd_addr, ext_addr;
    logic [7:0]  code_rdata, xd_wdata, xd_rdata, sfr_addr, sfr_wdata, sfr_rdata, ext_wdata;
    logic [7:0]  gpio_in, gpio_out, gpio_oe, irq0_event, irq1_event, wakeup_event;
    logic [7:0]  core_clock_select;
    int          errors = 0;
    int          checks_done = 0;
    // Data address beside expected {io read strobe, ATA select, internal valid}.
    logic [18:0] rows [9] = '{{16'h0000, 3'h4}, {16'h0400, 3'h1}, {16'h06FF, 3'h1},
        {16'h0700, 3'h4}, {16'h31F0, 3'h6}, {16'h31F7, 3'h6}, {16'h33F6, 3'h6},
        {16'h3F30, 3'h4}, {16'hFFFF, 3'h4}};
    mad_decoder #(.REVISION(8'h01), .IDENTITY(8'h5A)) i_dut (.sys_clk, .resetn, .code_req,
        .code_addr, .code_valid, .code_from_sram, .code_rdata, .xd_rd, .xd_wr, .xd_addr,
        .xd_wdata, .xd_valid, .xd_rdata, .sfr_rd, .sfr_wr, .sfr_addr, .sfr_wdata, .sfr_hit,
        .sfr_rdata, .ext_addr, .ext_wdata, .memory_read_strobe, .io_read_strobe,
        .io_write_strobe, .ata_select, .gpio_in, .gpio_out, .gpio_oe, .irq0_event,
        .irq1_event, .wakeup_event, .core_clock_select, .core_irq_input_a,
        .core_irq_input_b, .wakeup_irq_input, .pin_irq_input);
    mad_core_model m (.sys_clk, .xd_rd, .xd_wr, .xd_addr, .xd_wdata, .sfr_rd, .sfr_wr,
        .sfr_addr, .sfr_wdata);
    // ==========================================================
    // Helpers
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic fetch(input logic [15:0] a, input logic [1:0] exp);
        @(posedge sys_clk);
        code_req <= 1'b1;
        code_addr <= a;
        @(posedge sys_clk);
        code_req <= 1'b0;
        #1;
        chk({code_valid, code_from_sram, memory_read_strobe}, {1'b1, exp});
    endtask
    task automatic report_and_stop();
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ==========================================================
    // Stimulus
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // The whole run needs well under 200 cycles; a hang is cut at 2000.
    initial begin
        #200000;
        errors++;
        report_and_stop();
    end
    initial begin
        {resetn, code_req, code_addr, gpio_in, irq0_event, irq1_event, wakeup_event} = '0;
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        #1;
        chk({io_read_strobe, io_write_strobe, memory_read_strobe, core_irq_input_a}, 16'h0000);
        foreach (rows[i]) begin
            m.xd(1'b0, rows[i][18:3], 8'h00);
            #1;
            chk({io_read_strobe, ata_select, xd_valid}, rows[i][2:0]);
        end
        m.xd(1'b1, 16'h0410, 8'hA5);
        #1;
        chk({io_write_strobe, xd_valid}, 2'b01);
        m.xd(1'b0, 16'h0410, 8'h00);
        #1;
        chk(xd_rdata, 8'hA5);
        m.xd(1'b1, 16'h31F2, 8'h55);
        #1;
        chk({io_write_strobe, ata_select, xd_valid}, 16'h0006);
        chk(ext_addr, 16'h31F2);
        chk(ext_wdata, 16'h0055);
        m.special_function_region(1'b1, MAD_MISC_CONFIG, 8'h80);
        fetch(16'h0410, 2'b10);
        chk(code_rdata, 16'h00A5);
        fetch(16'h0700, 2'b01);
        m.special_function_region(1'b0, MAD_MISC_CONFIG, 8'h00);
        #1;
        chk({sfr_hit, sfr_rdata}, 9'h180);
        m.special_function_region(1'b1, MAD_MISC_CONFIG, 8'h00);
        fetch(16'h0500, 2'b01);
        fetch(16'h0000, 2'b01);
        m.special_function_region(1'b1, MAD_CHIP_REVISION, 8'hFF);
        m.special_function_region(1'b0, MAD_CHIP_REVISION, 8'h00);
        #1;
        chk({sfr_hit, sfr_rdata}, 9'h101);
        m.special_function_region(1'b1, MAD_IRQ0_MASK, 8'h01);
        irq0_event <= 8'h02;
        @(posedge sys_clk);
        irq0_event <= 8'h00;
        repeat (3) @(posedge sys_clk);
        #1;
        chk(core_irq_input_a, 16'h0000);
        m.special_function_region(1'b1, MAD_IRQ0_MASK, 8'h02);
        repeat (2) @(posedge sys_clk);
        #1;
        chk(core_irq_input_a, 16'h0001);
        m.special_function_region(1'b1, MAD_PIN_DIRECTION, 8'h0F);
        m.special_function_region(1'b1, MAD_PIN_OUT_VALUE, 8'h3C);
        m.special_function_region(1'b1, MAD_CLOCK_SELECT, 8'h21);
        m.special_function_region(1'b1, MAD_PIN_IRQ_MASK, 8'h10);
        gpio_in <= 8'h11;
        repeat (3) @(posedge sys_clk);
        #1;
        chk({gpio_oe, gpio_out}, 16'h0F3C);
        chk({core_clock_select, 7'h00, pin_irq_input}, 16'h2101);
        m.special_function_region(1'b0, MAD_PIN_IRQ_STAT, 8'h00);
        #1;
        chk({sfr_hit, sfr_rdata}, 16'h0110);
        m.special_function_region(1'b1, MAD_PIN_IRQ_STAT, 8'h10);
        @(posedge sys_clk);
        #1;
        chk(pin_irq_input, 16'h0000);
        m.special_function_region(1'b1, MAD_IRQ1_MASK, 8'h80);
        m.special_function_region(1'b1, MAD_WAKEUP_MASK, 8'h04);
        {irq1_event, wakeup_event} <= 16'h8004;
        @(posedge sys_clk);
        {irq1_event, wakeup_event} <= 16'h0000;
        @(posedge sys_clk);
        #1;
        chk({core_irq_input_b, wakeup_irq_input}, 16'h0003);
        resetn <= 1'b0;
        @(posedge sys_clk);
        resetn <= 1'b1;
        #1;
        chk({gpio_oe, core_irq_input_b, wakeup_irq_input, pin_irq_input}, 16'h0000);
        m.special_function_region(1'b0, MAD_MISC_CONFIG, 8'h00);
        #1;
        chk({sfr_hit, sfr_rdata}, 16'h0100);
        m.special_function_region(1'b0, MAD_PIN_IRQ_STAT, 8'h00);
        #1;
        chk({sfr_hit, sfr_rdata}, 16'h0100);
        report_and_stop();
    end
endmodule
`default_nettype wire
